// ---- change_detect.sv ----
`timescale 1ns/1ps
module change_detect (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Synchronised lines and enables
    input wire logic [dig_acq_pkg::LINES-1:0] line,
    input wire logic [dig_acq_pkg::LINES-1:0] rise_en,
    input wire logic [dig_acq_pkg::LINES-1:0] fall_en,
    // Merged event
    output logic event_out
);
    import dig_acq_pkg::*;
    typedef struct packed {
        logic [LINES-1:0] prev;
        logic primed;
        logic [2:0] win;
        logic evt;
    } cd_state_t;
    cd_state_t r;
    cd_state_t n;
    logic [LINES-1:0] hit;
    genvar i;
    generate
        for (i = 0; i < LINES; i++) begin : g_det
            assign hit[i] = r.primed & ((rise_en[i] & line[i] & ~r.prev[i])
                          | (fall_en[i] & ~line[i] & r.prev[i])); // [RULE5]
        end
    endgenerate
    // The first cycle only loads the history so that reset is not an edge.
    always_comb begin
        n = r;
        n.prev = line;
        n.primed = 1'b1;
        n.evt = 1'b0;
        if (r.win != 3'h0) begin
            n.win = r.win - 3'h1; // [RULE8]
        end else if (|hit) begin // [RULE7]
            n.evt = 1'b1;
            n.win = CD_WIN_CYC - 3'h1; // [RULE8]
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    assign event_out = r.evt;
endmodule

// ---- dig_acq_chk.sv ----
`timescale 1ns/1ps
module dig_acq_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [15:0] rdata,
    // Port pins
    input wire logic [15:0] gp_io_line_in,
    input wire logic [15:0] gp_io_line_out,
    input wire logic [15:0] gp_io_line_oe,
    // Trigger sources
    input wire logic counter_out,
    input wire logic other_trig,
    // Events and status
    input wire logic change_event,
    input wire logic overflow,
    input wire logic running
);
    import dig_acq_pkg::*;
    logic [15:0] mode_reg;
    logic [15:0] dly_reg;
    logic [15:0] pin_reg;
    logic [7:0] hist_reg;
    logic cmd_wr;
    logic clr_wr;
    assign cmd_wr = wr_stb && addr == REG_CMD;
    assign clr_wr = cmd_wr && wdata[CMD_CLR_OVF];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // The history only widens the event check, so a stale start is harmless.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= 16'h0000;
            dly_reg <= 16'h0002;
            pin_reg <= 16'h0000;
            hist_reg <= 8'h00;
        end else begin
            pin_reg <= gp_io_line_in;
            hist_reg <= {hist_reg[6:0], |(gp_io_line_in ^ pin_reg)};
            if (wr_stb && addr == REG_MODE) mode_reg <= wdata;
            if (wr_stb && addr == REG_DELAY) dly_reg <= wdata;
        end
    end
    a_reset_inputs: assert property (!$past(rstn) |-> gp_io_line_oe == 16'h0000)
        else $error("lines not inputs after reset");
    a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
        else $error("read data without a read");
    a_event_gap: assert property (change_event |=> !change_event [*4])
        else $error("change events too close");
    a_event_cause: assert property (change_event |-> hist_reg != 8'h00)
        else $error("change event without pin change");
    a_ovf_sticky: assert property ($past(overflow) && !$past(clr_wr) |-> overflow)
        else $error("overflow dropped");
    a_ovf_cause: assert property ($rose(overflow) |-> $past(running))
        else $error("overflow outside acquisition");
    a_stop_halts: assert property (cmd_wr && wdata[CMD_STOP] |=> !running)
        else $error("still running after stop");
    a_start_delay: assert property (cmd_wr && wdata[CMD_START] && !wdata[CMD_STOP]
        && !running && mode_reg == 16'h0000 && dly_reg == 16'h0002
        |=> !running ##1 !running ##1 running)
        else $error("start delay wrong");
    c_event: cover property (change_event);
    c_overflow: cover property ($rose(overflow));
    c_finish: cover property ($fell(running));
endmodule
bind digital_input_timing_and_change_detect dig_acq_chk i_chk (
    .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .gp_io_line_in(gp_io_line_in),
    .gp_io_line_out(gp_io_line_out), .gp_io_line_oe(gp_io_line_oe),
    .counter_out(counter_out), .other_trig(other_trig),
    .change_event(change_event), .overflow(overflow), .running(running));

// ---- dig_acq_pkg.sv ----
// Function
// RULE1 - Each line is set as input or output; static reads and writes are software commands.
// RULE2 - Finite mode stores exactly the programmed sample count, then stops itself.
// RULE3 - Continuous mode keeps sampling without limit until a stop command.
// RULE4 - Each selected sample clock edge stores the port lines as one FIFO sample.
// RULE5 - Sixteen per-line edge detectors, each enabled for rising, falling or both.
// RULE6 - Every input line is synchronised to the 100 MHz clock before detection.
// RULE7 - The change event is the OR of all enabled edge detectors.
// RULE8 - All edges inside one 50 ns window merge into one change event.
// RULE9 - The change event can drive a line, the sample clock, and an event output.
// RULE10 - A sample clock edge while the FIFO is full flags an overflow error.
// RULE11 - Sample clock from internal source with polarity, or any line with edge select.
// RULE12 - The sample clock exported on a line is driven inverted.
// RULE13 - Sample clock edges are ignored and nothing stored when not acquiring.
// RULE14 - Internal sample clock starts on trigger or software start, stops when finite ends.
// RULE15 - A configurable delay, default two timebase ticks, precedes the first sample clock.
// RULE16 - Timebase is 100 MHz, 20 MHz, 100 kHz or a line, then divided down.
// RULE17 - Timebase edge select except fixed 100 and 20 MHz; timebase never exported.
// RULE18 - With retrigger on, every start trigger repeats the whole clock sequence.
// RULE19 - Triggers during a running sequence are ignored; re-armed when it finishes.
// RULE20 - Trigger from a line, counter, change event or other trigger, edge selectable.
// RULE21 - The start trigger exported on a line is an active-high pulse.
// RULE22 - After reset every line is an input.
// RULE23 - Each sample is one 16-bit word, bit n from line n, same edge.
package dig_acq_pkg;
    localparam int LINES = 16;
    localparam int AW = 4;
    localparam int DW = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam int CLK_HZ = 100_000_000;
    localparam int TB20_HZ = 20_000_000;
    localparam int TB100K_HZ = 100_000;
    localparam int CLK_NS = 10;
    localparam int CD_WIN_NS = 50;
    localparam logic [9:0] TB20_CYC = 10'(CLK_HZ / TB20_HZ);
    localparam logic [9:0] TB100K_CYC = 10'(CLK_HZ / TB100K_HZ);
    localparam logic [9:0] TB100K_HALF = 10'(CLK_HZ / TB100K_HZ / 2);
    localparam logic [2:0] CD_WIN_CYC = 3'(CD_WIN_NS / CLK_NS);
    localparam logic [AW-1:0] REG_CMD = 4'h0;
    localparam logic [AW-1:0] REG_MODE = 4'h1;
    localparam logic [AW-1:0] REG_ROUTE = 4'h2;
    localparam logic [AW-1:0] REG_COUNT = 4'h3;
    localparam logic [AW-1:0] REG_DIV = 4'h4;
    localparam logic [AW-1:0] REG_DELAY = 4'h5;
    localparam logic [AW-1:0] REG_DIR = 4'h6;
    localparam logic [AW-1:0] REG_DOUT = 4'h7;
    localparam logic [AW-1:0] REG_DIN = 4'h8;
    localparam logic [AW-1:0] REG_CD_RISE = 4'h9;
    localparam logic [AW-1:0] REG_CD_FALL = 4'hA;
    localparam logic [AW-1:0] REG_EXPORT = 4'hB;
    localparam logic [AW-1:0] REG_STATUS = 4'hC;
    localparam logic [AW-1:0] REG_FIFO = 4'hD;
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_CLR_OVF = 2;
    localparam int MODE_CONT = 0;
    localparam int MODE_TRIG_EN = 1;
    localparam int MODE_RETRIG = 2;
    localparam int MODE_EXT = 3;
    localparam int MODE_SPOL = 4;
    localparam int MODE_TB_LO = 5;
    localparam int MODE_TBPOL = 7;
    localparam int MODE_TPOL = 8;
    localparam int MODE_INT_CD = 9;
    localparam int RT_SCLK_LO = 0;
    localparam int RT_TB_LO = 4;
    localparam int RT_TRIG_LO = 8;
    localparam int RT_TSRC_LO = 12;
    localparam int EX_SCLK_LO = 0;
    localparam int EX_SCLK_EN = 4;
    localparam int EX_TRIG_LO = 5;
    localparam int EX_TRIG_EN = 9;
    localparam int EX_CD_LO = 10;
    localparam int EX_CD_EN = 14;
    localparam logic [DW-1:0] MODE_RST = 16'h0000;
    localparam logic [DW-1:0] DIV_RST = 16'h0001;
    localparam logic [DW-1:0] DELAY_RST = 16'h0002;
    localparam logic [DW-1:0] DIR_RST = 16'h0000;
    typedef enum logic [1:0] {
        TB_100M = 2'b00, TB_20M = 2'b01, TB_100K = 2'b10, TB_LINE = 2'b11
    } tb_sel_t;
    typedef enum logic [1:0] {
        TS_LINE = 2'b00, TS_COUNTER = 2'b01, TS_CHANGE = 2'b10, TS_OTHER = 2'b11
    } trig_src_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_ARMED = 2'b01, ST_DELAY = 2'b10, ST_RUN = 2'b11
    } seq_state_t;
endpackage

// ---- digital_input_timing_and_change_detect.sv ----
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module digital_input_timing_and_change_detect (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [dig_acq_pkg::AW-1:0] addr,
    input wire logic [dig_acq_pkg::DW-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [dig_acq_pkg::DW-1:0] rdata,
    // Port pins
    input wire logic [dig_acq_pkg::LINES-1:0] gp_io_line_in,
    output logic [dig_acq_pkg::LINES-1:0] gp_io_line_out,
    output logic [dig_acq_pkg::LINES-1:0] gp_io_line_oe,
    // Internal trigger sources on this clock
    input wire logic counter_out,
    input wire logic other_trig,
    // Events and status
    output logic change_event,
    output logic overflow,
    output logic running
);
    import dig_acq_pkg::*;
    typedef struct packed {
        logic [LINES-1:0] din_s1;
        logic [LINES-1:0] din_s2;
        logic [DW-1:0] rdata;
        logic [LINES-1:0] io_out;
        logic [LINES-1:0] io_oe;
        logic [DW-1:0] mode;
        logic [DW-1:0] route;
        logic [DW-1:0] count;
        logic [DW-1:0] div;
        logic [DW-1:0] delay;
        logic [DW-1:0] dir;
        logic [DW-1:0] dout;
        logic [DW-1:0] cd_rise;
        logic [DW-1:0] cd_fall;
        logic [DW-1:0] export_sel;
        seq_state_t state;
        logic ovf;
        logic [9:0] tb_cnt;
        logic tb_prev;
        logic [DW-1:0] div_cnt;
        logic [DW-1:0] dly_cnt;
        logic [DW-1:0] smp_cnt;
        logic sclk_prev;
        logic trig_prev;
        logic int_clk;
        logic trig_pulse;
        logic cd_q;
        logic run;
    } top_state_t;
    top_state_t r;
    top_state_t n;
    sample_fifo_if fifo ();
    logic cd_raw;
    logic wr_cmd;
    logic start_cmd;
    logic stop_cmd;
    logic tb_lvl;
    logic tb_tick;
    logic trig_lvl;
    logic trig_edge;
    logic sclk_lvl;
    logic sclk_edge;
    logic finite_done;
    logic [DW-1:0] smp_inc;
    tb_sel_t tb_sel;
    trig_src_t trig_src;

    change_detect u_cd (
        .mclk(mclk),
        .rstn(rstn),
        .line(r.din_s2),
        .rise_en(r.cd_rise),
        .fall_en(r.cd_fall),
        .event_out(cd_raw)
    );

    sample_fifo u_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .f(fifo.store)
    );

    always_comb begin
        n = r;
        fifo.push = 1'b0;
        fifo.pop = 1'b0;
        // Bit n of a sample is line n, all from one synchronised edge.
        fifo.wdata = r.din_s2; // [RULE23]
        n.din_s1 = gp_io_line_in;
        n.din_s2 = r.din_s1; // [RULE6]
        n.cd_q = cd_raw; // [RULE9]
        n.int_clk = 1'b0;
        n.trig_pulse = 1'b0;
        n.rdata = '0;

        wr_cmd = wr_stb && (addr == REG_CMD);
        start_cmd = wr_cmd && wdata[CMD_START];
        stop_cmd = wr_cmd && wdata[CMD_STOP];

        // Timebase tick; the fixed 100 and 20 MHz sources have no edge select.
        tb_sel = tb_sel_t'(r.mode[MODE_TB_LO +: 2]);
        tb_lvl = r.din_s2[r.route[RT_TB_LO +: 4]];
        n.tb_prev = tb_lvl;
        n.tb_cnt = r.tb_cnt + 10'h001;
        tb_tick = 1'b0;
        case (tb_sel)
            TB_100M: begin
                tb_tick = 1'b1; // [RULE16]
                n.tb_cnt = '0;
            end
            TB_20M: begin
                if (r.tb_cnt >= TB20_CYC - 10'h001) begin
                    tb_tick = 1'b1; // [RULE16]
                    n.tb_cnt = '0;
                end
            end
            TB_100K: begin
                if (r.tb_cnt >= TB100K_CYC - 10'h001) begin
                    n.tb_cnt = '0;
                end
                if (r.mode[MODE_TBPOL]) begin
                    tb_tick = (r.tb_cnt == TB100K_HALF); // [RULE17]
                end else begin
                    tb_tick = (r.tb_cnt == 10'h000); // [RULE16]
                end
            end
            TB_LINE: begin
                n.tb_cnt = '0;
                if (r.mode[MODE_TBPOL]) begin
                    tb_tick = r.tb_prev && !tb_lvl; // [RULE17]
                end else begin
                    tb_tick = !r.tb_prev && tb_lvl; // [RULE17]
                end
            end
            default: begin
                tb_tick = 1'b0;
                n.tb_cnt = '0;
            end
        endcase

        // Start trigger source and edge.
        trig_src = trig_src_t'(r.route[RT_TSRC_LO +: 2]);
        case (trig_src)
            TS_LINE: trig_lvl = r.din_s2[r.route[RT_TRIG_LO +: 4]]; // [RULE20]
            TS_COUNTER: trig_lvl = counter_out; // [RULE20]
            TS_CHANGE: trig_lvl = r.cd_q; // [RULE20]
            TS_OTHER: trig_lvl = other_trig; // [RULE20]
            default: trig_lvl = 1'b0;
        endcase
        n.trig_prev = trig_lvl;
        if (r.mode[MODE_TPOL]) begin
            trig_edge = r.trig_prev && !trig_lvl; // [RULE20]
        end else begin
            trig_edge = !r.trig_prev && trig_lvl; // [RULE20]
        end

        // Sample clock source and edge.
        if (r.mode[MODE_EXT]) begin
            sclk_lvl = r.din_s2[r.route[RT_SCLK_LO +: 4]]; // [RULE11]
        end else if (r.mode[MODE_INT_CD]) begin
            sclk_lvl = r.cd_q; // [RULE9]
        end else begin
            sclk_lvl = r.int_clk; // [RULE11]
        end
        n.sclk_prev = sclk_lvl;
        // Internal sources are one-cycle pulses, so the pulse is the edge.
        if (!r.mode[MODE_EXT]) begin
            sclk_edge = r.mode[MODE_SPOL] ? r.sclk_prev : sclk_lvl;
        end else if (r.mode[MODE_SPOL]) begin
            sclk_edge = r.sclk_prev && !sclk_lvl; // [RULE11]
        end else begin
            sclk_edge = !r.sclk_prev && sclk_lvl; // [RULE11]
        end

        // Register writes.
        if (wr_stb) begin
            case (addr)
                REG_CMD: begin
                    if (wdata[CMD_CLR_OVF]) begin
                        n.ovf = 1'b0;
                    end
                end
                REG_MODE: n.mode = wdata;
                REG_ROUTE: n.route = wdata;
                REG_COUNT: n.count = wdata;
                REG_DIV: n.div = wdata;
                REG_DELAY: n.delay = wdata;
                REG_DIR: n.dir = wdata; // [RULE1]
                REG_DOUT: n.dout = wdata; // [RULE1]
                REG_CD_RISE: n.cd_rise = wdata; // [RULE5]
                REG_CD_FALL: n.cd_fall = wdata; // [RULE5]
                REG_EXPORT: n.export_sel = wdata;
                default: n.mode = r.mode;
            endcase
        end

        // Register reads; data stand in the following cycle.
        if (rd_stb) begin
            case (addr)
                REG_MODE: n.rdata = r.mode;
                REG_ROUTE: n.rdata = r.route;
                REG_COUNT: n.rdata = r.count;
                REG_DIV: n.rdata = r.div;
                REG_DELAY: n.rdata = r.delay;
                REG_DIR: n.rdata = r.dir;
                REG_DOUT: n.rdata = r.dout;
                REG_DIN: n.rdata = r.din_s2; // [RULE1]
                REG_CD_RISE: n.rdata = r.cd_rise;
                REG_CD_FALL: n.rdata = r.cd_fall;
                REG_EXPORT: n.rdata = r.export_sel;
                REG_STATUS: begin
                    n.rdata = {11'h000, fifo.full, fifo.empty, r.ovf,
                               r.state};
                end
                REG_FIFO: begin
                    if (!fifo.empty) begin
                        n.rdata = fifo.head;
                        fifo.pop = 1'b1;
                    end
                end
                default: n.rdata = '0;
            endcase
        end

        // Sequencer.
        smp_inc = r.smp_cnt + 16'h0001;
        finite_done = 1'b0;
        case (r.state)
            ST_IDLE: begin
                if (start_cmd) begin
                    n.smp_cnt = '0;
                    n.dly_cnt = '0;
                    n.div_cnt = '0;
                    if (r.mode[MODE_TRIG_EN]) begin
                        n.state = ST_ARMED;
                    end else if (r.mode[MODE_EXT]) begin
                        n.state = ST_RUN;
                    end else begin
                        n.state = ST_DELAY; // [RULE14]
                    end
                end
            end
            ST_ARMED: begin
                if (trig_edge) begin
                    n.trig_pulse = 1'b1; // [RULE21]
                    n.smp_cnt = '0;
                    n.dly_cnt = '0;
                    n.div_cnt = '0;
                    if (r.mode[MODE_EXT]) begin
                        n.state = ST_RUN;
                    end else begin
                        n.state = ST_DELAY; // [RULE14]
                    end
                end
            end
            ST_DELAY: begin
                // Triggers are not looked at here or while running.
                if (tb_tick) begin // [RULE19]
                    if (r.dly_cnt + 16'h0001 >= r.delay) begin
                        n.int_clk = 1'b1; // [RULE15]
                        n.state = ST_RUN;
                    end else begin
                        n.dly_cnt = r.dly_cnt + 16'h0001; // [RULE15]
                    end
                end
            end
            ST_RUN: begin
                if (!r.mode[MODE_EXT] && tb_tick) begin
                    if (r.div_cnt + 16'h0001 >= r.div) begin
                        n.int_clk = 1'b1; // [RULE16]
                        n.div_cnt = '0;
                    end else begin
                        n.div_cnt = r.div_cnt + 16'h0001;
                    end
                end
                if (sclk_edge) begin
                    if (fifo.full) begin
                        n.ovf = 1'b1; // [RULE10]
                    end else begin
                        fifo.push = 1'b1; // [RULE4]
                        n.smp_cnt = smp_inc;
                        finite_done = !r.mode[MODE_CONT]
                                      && (smp_inc >= r.count); // [RULE2]
                    end
                end
                if (finite_done) begin
                    n.smp_cnt = '0;
                    if (r.mode[MODE_RETRIG]) begin
                        n.state = ST_ARMED; // [RULE18]
                    end else begin
                        n.state = ST_IDLE; // [RULE14]
                    end
                end
            end
            default: n.state = ST_IDLE;
        endcase
        // Continuous runs end only here; a stop wins over the state and int_clk set above.
        if (stop_cmd) begin
            n.state = ST_IDLE; // [RULE3]
            n.int_clk = 1'b0;
        end
        n.run = (n.state == ST_RUN);

        // Pin drive; the timebase has no export path at all.
        n.io_out = r.dout;
        n.io_oe = r.dir; // [RULE1]
        if (r.export_sel[EX_SCLK_EN]) begin
            n.io_out[r.export_sel[EX_SCLK_LO +: 4]] = !sclk_lvl; // [RULE12]
            n.io_oe[r.export_sel[EX_SCLK_LO +: 4]] = 1'b1;
        end
        if (r.export_sel[EX_TRIG_EN]) begin
            n.io_out[r.export_sel[EX_TRIG_LO +: 4]] = r.trig_pulse; // [RULE21]
            n.io_oe[r.export_sel[EX_TRIG_LO +: 4]] = 1'b1;
        end
        if (r.export_sel[EX_CD_EN]) begin
            n.io_out[r.export_sel[EX_CD_LO +: 4]] = r.cd_q; // [RULE9]
            n.io_oe[r.export_sel[EX_CD_LO +: 4]] = 1'b1;
        end
    end

    // Sample clock edges outside ST_RUN never reach the FIFO.
    always_ff @(posedge mclk or negedge rstn) begin // [RULE13]
        if (!rstn) begin
            r <= '0;
            r.mode <= MODE_RST;
            r.div <= DIV_RST;
            r.delay <= DELAY_RST; // [RULE15]
            r.dir <= DIR_RST; // [RULE22]
            r.state <= ST_IDLE;
        end else begin
            r <= n;
        end
    end

    assign rdata = r.rdata;
    assign gp_io_line_out = r.io_out;
    assign gp_io_line_oe = r.io_oe;
    assign change_event = r.cd_q; // [RULE9]
    assign overflow = r.ovf;
    assign running = r.run;
endmodule

// ---- pin_model.sv ----
`timescale 1ns/1ps
module pin_model (
    // Drive from the block
    input wire logic [15:0] oe,
    input wire logic [15:0] drv,
    // Level applied from outside
    input wire logic [15:0] ext,
    // Resolved pin levels
    output logic [15:0] pins
);
    // A driven line shows the block's value, so static outputs read back.
    assign pins = (oe & drv) | (~oe & ext);
endmodule

// ---- sample_fifo.sv ----
`timescale 1ns/1ps
module sample_fifo (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Store side
    sample_fifo_if.store f
);
    import dig_acq_pkg::*;
    typedef struct packed {
        logic [FIFO_DEPTH-1:0][DW-1:0] mem;
        logic [FIFO_AW-1:0] wr_ptr;
        logic [FIFO_AW-1:0] rd_ptr;
        logic [FIFO_AW:0] count;
        logic [DW-1:0] head;
    } fifo_state_t;
    fifo_state_t r;
    fifo_state_t n;
    logic do_push;
    logic do_pop;
    logic [FIFO_AW-1:0] rd_nxt;
    // The head word is prefetched so a pop returns data with no extra wait.
    always_comb begin
        n = r;
        do_push = f.push && (r.count != (FIFO_AW+1)'(FIFO_DEPTH));
        do_pop = f.pop && (r.count != '0);
        rd_nxt = do_pop ? r.rd_ptr + 4'h1 : r.rd_ptr;
        if (do_push) begin
            n.mem[r.wr_ptr] = f.wdata;
            n.wr_ptr = r.wr_ptr + 4'h1;
        end
        n.rd_ptr = rd_nxt;
        n.head = n.mem[rd_nxt];
        if (do_push && !do_pop) begin
            n.count = r.count + 5'h01;
        end else if (do_pop && !do_push) begin
            n.count = r.count - 5'h01;
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    assign f.head = r.head;
    assign f.full = (r.count == (FIFO_AW+1)'(FIFO_DEPTH));
    assign f.empty = (r.count == '0);
endmodule

// ---- sample_fifo_if.sv ----
`timescale 1ns/1ps
interface sample_fifo_if;
    logic push;
    logic pop;
    logic [15:0] wdata;
    logic [15:0] head;
    logic full;
    logic empty;
    modport fill (output push, output pop, output wdata,
                  input head, input full, input empty);
    modport store (input push, input pop, input wdata,
                   output head, output full, output empty);
endinterface

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    import dig_acq_pkg::*;
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_stb = 1'h0;
    logic rd_stb = 1'h0;
    logic counter_out = 1'h0;
    logic [15:0] ext = 16'h0000;
    logic [15:0] rdata, pins, pout, poe;
    logic change_event, overflow, running;
    int err_total = 0;
    int samples_checked = 0;
    int n;
    always #5 mclk = ~mclk;
    pin_model i_pins (.oe(poe), .drv(pout), .ext(ext), .pins(pins));
    digital_input_timing_and_change_detect i_dut (.mclk(mclk), .rstn(rstn),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .gp_io_line_in(pins), .gp_io_line_out(pout),
        .gp_io_line_oe(poe), .counter_out(counter_out), .other_trig(1'h0),
        .change_event(change_event), .overflow(overflow), .running(running));
    task automatic end_of_test;
        $display("mismatches %0d, checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr_stb <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr_stb <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        rd_stb <= 1'h1;
        addr <= a;
        @(posedge mclk);
        rd_stb <= 1'h0;
        @(negedge mclk);
        chk(rdata, exp);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 300; i++) begin
            @(negedge mclk);
            if (running === 1'h0) return;
        end
        err_total++;
        end_of_test();
    endtask
    // The second value lands two cycles later, inside one merge window.
    task automatic events(input logic [15:0] v1, input logic [15:0] v2,
                          input logic [15:0] exp);
        @(posedge mclk);
        ext <= v1;
        repeat (2) @(posedge mclk);
        ext <= v2;
        n = 0;
        repeat (12) begin
            @(negedge mclk);
            if (change_event === 1'h1) n++;
        end
        chk(16'(n), exp);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'h1;
        chk(poe, 16'h0000);
        rd(REG_MODE, MODE_RST);
        rd(REG_DIV, DIV_RST);
        rd(REG_DELAY, DELAY_RST);
        rd(REG_DIR, DIR_RST);
        rd(4'hE, 16'h0000);
        ext <= 16'h3C00;
        wr(REG_DIR, 16'h00FF);
        wr(REG_DOUT, 16'h00A5);
        repeat (4) @(negedge mclk);
        chk(poe, 16'h00FF);
        rd(REG_DIN, 16'h3CA5);
        wr(REG_DIR, 16'h0000);
        wr(REG_EXPORT, 16'h0013);
        repeat (2) @(negedge mclk);
        chk(poe & pout & 16'h0008, 16'h0008);
        wr(REG_EXPORT, 16'h0000);
        ext <= 16'h1234;
        wr(REG_COUNT, 16'h0003);
        wr(REG_CMD, 16'h0001);
        repeat (4) @(negedge mclk);
        chk({15'h0000, running}, 16'h0001);
        wait_idle();
        repeat (10) @(posedge mclk);
        for (int i = 0; i < 3; i++) rd(REG_FIFO, 16'h1234);
        rd(REG_STATUS, 16'h0008);
        ext <= 16'h8001;
        wr(REG_MODE, 16'h0001);
        wr(REG_CMD, 16'h0001);
        repeat (40) @(posedge mclk);
        rd(REG_STATUS, 16'h0017);
        wr(REG_CMD, 16'h0002);
        wr(REG_CMD, 16'h0004);
        @(negedge mclk);
        chk({14'h0000, running, overflow}, 16'h0000);
        for (int i = 0; i < 16; i++) rd(REG_FIFO, 16'h8001);
        rd(REG_FIFO, 16'h0000);
        ext <= 16'h4C3A;
        wr(REG_COUNT, 16'h0002);
        wr(REG_MODE, 16'h0006);
        wr(REG_ROUTE, 16'h1000);
        wr(REG_CMD, 16'h0001);
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk);
            counter_out <= 1'h1;
            @(posedge mclk);
            counter_out <= 1'h0;
            repeat (k == 0 ? 0 : 20) @(posedge mclk);
        end
        wr(REG_CMD, 16'h0002);
        for (int i = 0; i < 4; i++) rd(REG_FIFO, 16'h4C3A);
        rd(REG_FIFO, 16'h0000);
        ext <= 16'h0002;
        wr(REG_CD_RISE, 16'h0001);
        wr(REG_CD_FALL, 16'h0002);
        repeat (8) @(posedge mclk);
        events(16'h0003, 16'h0003, 16'h0001);
        events(16'h0002, 16'h0002, 16'h0000);
        events(16'h0012, 16'h0012, 16'h0000);
        events(16'h0000, 16'h0000, 16'h0001);
        events(16'h0002, 16'h0002, 16'h0000);
        events(16'h0003, 16'h0001, 16'h0001);
        end_of_test();
    end
endmodule
